// file: dv/highway_master_model.sv
/* Behavioural highway master: shift or data clock and frame sync.
   Assumes the bench raises run_i to send whole frames; clock idles low. */
`default_nettype none
module highway_master_model #(
    parameter int HALF_NS = 160,
    parameter int FRAME_CLKS = 128
) (
    // Control
    input wire logic run_i,
    input wire logic gci_i,
    // Highway pins
    output logic shift_clk_o,
    output logic frame_sync_o,
    output logic gci_frame_sync_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        shift_clk_o = 1'b0;
        frame_sync_o = 1'b0;
        gci_frame_sync_o = 1'b0;
        #7;
        forever begin
            // Clock stands still between frames; a started frame runs whole
            wait (run_i);
            for (int b = 0; b < FRAME_CLKS; b++) begin
                frame_sync_o = !gci_i && b == 0;
                gci_frame_sync_o = gci_i && b == 0;
                #HALF_NS shift_clk_o = 1'b1;
                #HALF_NS shift_clk_o = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// file: dv/highway_slot_ctrl_monitor.sv
/* Concurrent checks on the ports of the highway slot-control block.
   Assumes it is bound to that block; clk_i at 25 MHz, rst_i synchronous. */
`default_nettype none
`include "highway_regs.svh"
module highway_slot_ctrl_monitor (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Pins
    input wire logic reset_n_i,
    input wire logic tx_highway_port_a_oe_o,
    input wire logic tx_highway_port_b_oe_o,
    input wire logic gci_upstream_line_oe_o,
    input wire logic slot_ctrl_out_a_o,
    input wire logic slot_ctrl_out_a_oe_o,
    input wire logic slot_ctrl_out_b_o,
    input wire logic slot_ctrl_out_b_oe_o,
    input wire logic dsp_clk_tick_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Data writes may stall on a full buffer, so they are left out
    sequence req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i != `REG_TXDATA_OFS;
    endsequence
    // Sync flops plus a register stage lie between the pin and the outputs
    sequence pin_low_s;
        !reset_n_i [*5];
    endsequence
    sequence quiet_s;
        !tx_highway_port_a_oe_o && !tx_highway_port_b_oe_o && !gci_upstream_line_oe_o
            && !slot_ctrl_out_a_oe_o && !slot_ctrl_out_b_oe_o;
    endsequence
    ack_resp_a: assert property (req_s |=> wb_ack_o)
        else $error("bus request not acknowledged next cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    rdat_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside acknowledge");
    od_level_a: assert property (!slot_ctrl_out_a_o && !slot_ctrl_out_b_o)
        else $error("slot control drives high");
    slot_a_tx_a: assert property (
        tx_highway_port_a_oe_o || gci_upstream_line_oe_o |-> slot_ctrl_out_a_oe_o)
        else $error("slot control A not pulled while sending");
    slot_b_tx_a: assert property (tx_highway_port_b_oe_o == slot_ctrl_out_b_oe_o)
        else $error("slot control B differs from port B drive");
    pin_reset_a: assert property (pin_low_s |-> quiet_s)
        else $error("outputs driven while reset pin low");
    rst_quiet_a: assert property ($fell(rst_i) |-> quiet_s ##0 !wb_ack_o)
        else $error("outputs driven after reset");
    tick_pulse_a: assert property (dsp_clk_tick_o |=> !dsp_clk_tick_o)
        else $error("processor tick longer than one cycle");
endmodule
`default_nettype wire

// file: dv/tb.sv
/* Self-checking bench of the highway slot-control block.
   Assumes the master model on the highway and pull-ups on released pins. */
`default_nettype none
`include "highway_regs.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, reset_n_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd, cap;
    logic shift_clk_i, frame_sync_in_i, gci_frame_sync_in_i, master_clk_i;
    logic gci_slot_select_hi_i, gci_slot_select_lo_i, run, gci, use_b;
    logic tx_a, tx_a_oe, tx_b, tx_b_oe, up, up_oe, sc_a, sc_a_oe, sc_b, sc_b_oe;
    logic dsp_clk_tick_o, gci_fast_clk_o, slot_line, data_line;
    logic [4:0] mcnt;
    int n_fail, samples_checked, n_cap, n_edge, n_tick;
    highway_slot_ctrl highway_slot_ctrl_i (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .shift_clk_i(shift_clk_i), .frame_sync_in_i(frame_sync_in_i),
        .gci_frame_sync_in_i(gci_frame_sync_in_i), .master_clk_i(master_clk_i),
        .reset_n_i(reset_n_i), .gci_slot_select_hi_i(gci_slot_select_hi_i),
        .gci_slot_select_lo_i(gci_slot_select_lo_i),
        .tx_highway_port_a_o(tx_a), .tx_highway_port_a_oe_o(tx_a_oe),
        .tx_highway_port_b_o(tx_b), .tx_highway_port_b_oe_o(tx_b_oe),
        .gci_upstream_line_o(up), .gci_upstream_line_oe_o(up_oe),
        .slot_ctrl_out_a_o(sc_a), .slot_ctrl_out_a_oe_o(sc_a_oe),
        .slot_ctrl_out_b_o(sc_b), .slot_ctrl_out_b_oe_o(sc_b_oe),
        .dsp_clk_tick_o(dsp_clk_tick_o), .gci_fast_clk_o(gci_fast_clk_o));
    highway_master_model highway_master_model_i (.run_i(run), .gci_i(gci),
        .shift_clk_o(shift_clk_i), .frame_sync_o(frame_sync_in_i),
        .gci_frame_sync_o(gci_frame_sync_in_i));
    // Released pins read high through their pull-ups
    assign slot_line = use_b ? (sc_b_oe ? sc_b : 1'b1) : (sc_a_oe ? sc_a : 1'b1);
    assign data_line = gci ? (up_oe ? up : 1'b1) : use_b ? (tx_b_oe ? tx_b : 1'b1)
        : (tx_a_oe ? tx_a : 1'b1);
    assign master_clk_i = mcnt[4];
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        mcnt <= mcnt + 5'h01;
        if (dsp_clk_tick_o === 1'b1) n_tick <= n_tick + 1;
    end
    // Bits are taken on the link clock edge after the one that sends them, where they are settled
    always @(posedge shift_clk_i) begin
        if (slot_line === 1'b0) begin
            cap <= {cap[30:0], data_line};
            n_cap <= n_cap + 1;
        end
        n_edge <= n_edge + 1;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task results();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 2000);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 2000) begin
            n_fail++;
            results();
        end
    endtask
    // One frame at a time; the far side stalls between frames
    task automatic frame(input int bits);
        int n;
        n_cap = 0;
        n_edge = 0;
        n_tick = 0;
        run = 1'b1;
        n = 0;
        while (n_cap < bits && n < 5000) begin
            @(posedge clk_i);
            n++;
        end
        run = 1'b0;
        if (n >= 5000) begin
            n_fail++;
            results();
        end
        repeat (1200) @(posedge clk_i);
        check("slot_bits", n_cap, bits);
    endtask
    task t_pcm();
        wb(1'b1, `REG_SLOT_OFS, 32'h0000_0001);
        wb(1'b1, `REG_TXDATA_OFS, 32'h0000_00A5);
        frame(8);
        check("pcm_a", cap[7:0], 8'hA5);
        use_b = 1'b1;
        wb(1'b1, `REG_CTRL_OFS, 32'h0000_000E);
        wb(1'b1, `REG_TXDATA_OFS, 32'h0000_005A);
        frame(16);
        check("dbl_b", cap[15:0], 16'h33CC);
        check("dsp_ticks", n_tick, n_edge);
        use_b = 1'b0;
    endtask
    task t_gci();
        gci = 1'b1;
        gci_slot_select_lo_i <= 1'b1;
        wb(1'b1, `REG_CTRL_OFS, 32'h0000_0001);
        frame(32);
        wb(1'b1, `REG_TXDATA_OFS, 32'h0000_00C3);
        frame(32);
        check("gci_b1", cap[31:16], 16'hF00F);
        check("gci_fast", gci_fast_clk_o, 1'b1);
        wb(1'b0, `REG_STATUS_OFS, 32'h0);
        check("stat_fast", rd[0], 1'b1);
        gci = 1'b0;
    endtask
    task t_pin_reset();
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        wb(1'b0, `REG_CTRL_OFS, 32'h0);
        check("ctrl_pin_rst", rd, 32'h0);
        wb(1'b0, `REG_SLOT_OFS, 32'h0);
        check("slot_pin_rst", rd, 32'h0);
    endtask
    task t_fifo();
        for (int i = 0; i < 32; i++) wb(1'b1, `REG_TXDATA_OFS, 32'(i));
        wb(1'b0, `REG_STATUS_OFS, 32'h0);
        check("fifo_full", rd[3:2], 2'b10);
        for (int i = 0; i < 32; i++) begin
            frame(8);
            check("fifo_order", cap[7:0], 8'(i));
        end
        wb(1'b0, `REG_STATUS_OFS, 32'h0);
        check("fifo_empty", rd[3:2], 2'b01);
    endtask
    initial begin
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, run, gci, use_b} = '0;
        {gci_slot_select_hi_i, gci_slot_select_lo_i} = '0;
        reset_n_i = 1'b1;
        wb_sel_i = 4'hF;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0;
        cap = 32'h0;
        mcnt = 5'h00;
        {n_fail, samples_checked, n_cap, n_edge, n_tick} = '0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, `REG_CTRL_OFS, 32'h0);
        check("ctrl_reset", rd, 32'h0);
        wb(1'b0, `REG_STATUS_OFS, 32'h0);
        check("stat_reset", rd[3:0], 4'h4);
        wb(1'b1, 8'h10, 32'hFFFF_FFFF);
        wb(1'b0, 8'h10, 32'h0);
        check("unmapped", rd, 32'h0);
        t_pcm();
        t_gci();
        t_pin_reset();
        t_fifo();
        results();
    end
endmodule
bind highway_slot_ctrl highway_slot_ctrl_monitor highway_slot_ctrl_monitor_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .reset_n_i(reset_n_i),
    .tx_highway_port_a_oe_o(tx_highway_port_a_oe_o),
    .tx_highway_port_b_oe_o(tx_highway_port_b_oe_o),
    .gci_upstream_line_oe_o(gci_upstream_line_oe_o),
    .slot_ctrl_out_a_o(slot_ctrl_out_a_o), .slot_ctrl_out_a_oe_o(slot_ctrl_out_a_oe_o),
    .slot_ctrl_out_b_o(slot_ctrl_out_b_o), .slot_ctrl_out_b_oe_o(slot_ctrl_out_b_oe_o),
    .dsp_clk_tick_o(dsp_clk_tick_o));
`default_nettype wire

// file: verilog/highway_pkg.sv
/*
 * Types shared by the highway block: mode control word, pin drive pair and
 * transmit state.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package highway_pkg;

    typedef struct packed {
        logic port_b;
        logic dsp_from_shift;
        logic double_clk;
        logic gci_mode;
    } mode_ctrl_t;

    typedef struct packed {
        logic out;
        logic oe;
    } pin_drive_t;

    typedef enum logic [0:0] {
        TX_IDLE = 1'b0,
        TX_SHIFT = 1'b1
    } tx_state_t;

endpackage

`default_nettype wire

// file: verilog/highway_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * highway clock and slot-control block.
 * Assumes a 25 MHz system clock and a byte-addressed 32-bit Wishbone bus.
 */
`ifndef HIGHWAY_REGS_SVH
`define HIGHWAY_REGS_SVH

`define REG_CTRL_OFS 8'h00
`define REG_SLOT_OFS 8'h04
`define REG_TXDATA_OFS 8'h08
`define REG_STATUS_OFS 8'h0C

`define CTRL_GCI_MODE_BIT 0
`define CTRL_DOUBLE_CLK_BIT 1
`define CTRL_DSP_FROM_SHIFT_BIT 2
`define CTRL_PORT_B_BIT 3
`define CTRL_RESET 4'h0
`define SLOT_RESET 7'h00

`define STAT_FAST_BIT 0
`define STAT_FRAMED_BIT 1
`define STAT_EMPTY_BIT 2
`define STAT_FULL_BIT 3
`define STAT_PERIOD_LSB 8

`define SYS_CLK_KHZ 25000
`define GCI_MID_PERIOD_NS 366
`define GCI_FAST_CYCLES ((`GCI_MID_PERIOD_NS * `SYS_CLK_KHZ) / 1000000)

`define SYNC_RESET 7'h10
`define IDLE_BYTE 8'hFF

`endif

// file: verilog/highway_slot_ctrl.sv
/*
 * Highway clocking and slot control: samples the shift/data clock and frame
 * sync, detects the GCI clock rate, derives the bit tick, shifts buffered
 * bytes out in the assigned slot and drives the open-drain slot-control pins.
 * Assumes a classic Wishbone master on clk_i and pins from another domain.
 */
// Local design decisions: register access over Wishbone and the placing of the registers.
`default_nettype none

`include "highway_regs.svh"

// Contract
// R1: Master shift clock is whole multiple of frame.
// R2: Shift clock between 128/256 kHz and 8.192 MHz.
// R3: Linear or signalling modes need doubled minimum.
// R4: Master avoids 1.03 to 1.53 MHz band.
// R5: Signal-processor clock selectable from shift clock.
// R6: Double-clock option shifts one bit per two clocks.
// R7: GCI clock 2.048 or 4.096 MHz, detected.
// R8: Fast GCI clock still gives 2.048 Mbit/s.
// R9: Low reset pin returns everything to default.
// R10: Slot-control pins are open-drain, released otherwise.
// R11: PCM mode pulls A or B while transmitting.
// R12: GCI mode pulls A during selected slots.
// R13: PCM frame sync marks time slot zero.
// R14: GCI frame sync starts channel count at zero.
module highway_slot_ctrl
    import highway_pkg::*;
#(
    parameter int FIFO_DEPTH = 32
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Highway pins in
    input wire logic shift_clk_i,
    input wire logic frame_sync_in_i,
    input wire logic gci_frame_sync_in_i,
    input wire logic master_clk_i,
    input wire logic reset_n_i,
    input wire logic gci_slot_select_hi_i,
    input wire logic gci_slot_select_lo_i,
    // Highway data out
    output logic tx_highway_port_a_o,
    output logic tx_highway_port_a_oe_o,
    output logic tx_highway_port_b_o,
    output logic tx_highway_port_b_oe_o,
    output logic gci_upstream_line_o,
    output logic gci_upstream_line_oe_o,
    // Open-drain slot control
    output logic slot_ctrl_out_a_o,
    output logic slot_ctrl_out_a_oe_o,
    output logic slot_ctrl_out_b_o,
    output logic slot_ctrl_out_b_oe_o,
    // Clock status
    output logic dsp_clk_tick_o,
    output logic gci_fast_clk_o
);

    localparam int NPIN = 7;
    // Idle levels of the pins, so no false edge follows reset
    localparam logic [NPIN-1:0] SYNC_INIT = `SYNC_RESET;

    // Synchronisers
    logic [NPIN-1:0] sync1_reg;
    logic [NPIN-1:0] sync2_reg;
    logic [NPIN-1:0] sync3_reg;
    wire logic [NPIN-1:0] pins_raw;

    // Control and status
    mode_ctrl_t ctrl_reg;
    logic [6:0] slot_reg;
    logic [7:0] period_reg;
    logic [7:0] per_cnt_reg;
    logic fast_reg;
    logic framed_reg;
    logic fs_prev_reg;
    logic div_reg;
    logic [9:0] bit_cnt_reg;
    logic [7:0] shreg_reg;
    tx_state_t state_reg;
    logic bit_reg;

    // Registered outputs
    logic [31:0] rdata_reg;
    logic ack_reg;
    pin_drive_t port_a_reg;
    pin_drive_t port_b_reg;
    pin_drive_t up_reg;
    pin_drive_t sc_a_reg;
    pin_drive_t sc_b_reg;
    logic dsp_tick_reg;

    // Decode
    wire logic srst;
    wire logic clk_rise;
    wire logic mclk_rise;
    wire logic fs_lvl;
    wire logic frame_start;
    wire logic half_rate;
    wire logic bit_tick;
    wire logic advance;
    wire logic [9:0] next_pos;
    wire logic win;
    wire logic load;
    wire logic bus_req;
    wire logic sel_ctrl;
    wire logic sel_slot;
    wire logic sel_txdata;
    wire logic sel_status;
    wire logic tx_push;
    wire logic ack_next;
    wire logic wr_en;
    wire logic [31:0] rdata_next;
    wire logic [31:0] status_word;
    wire logic fifo_in_ready;
    wire logic fifo_out_valid;
    wire logic [7:0] fifo_out_data;
    wire logic fifo_full;
    wire logic fifo_empty;

    // Bit position inside the frame's transmit window
    function automatic logic slot_window(input logic [9:0] pos, input logic gci,
                                         input logic [6:0] slot, input logic [1:0] chan);
        if (gci) begin
            // Channel of 32 bits, B1 and B2 are its first two bytes
            slot_window = (pos[9:8] == 2'b00) && (pos[7:5] == {1'b0, chan}) && !pos[4];
        end else begin
            slot_window = (pos[9:3] == slot);
        end
    endfunction

    function automatic logic is_addr(input logic [7:0] adr, input logic [7:0] ofs);
        is_addr = (adr[7:2] == ofs[7:2]);
    endfunction

    assign pins_raw = {gci_slot_select_lo_i, gci_slot_select_hi_i, reset_n_i, master_clk_i,
                       gci_frame_sync_in_i, frame_sync_in_i, shift_clk_i};

    // Two flops per pin before any logic reads it
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    sync1_reg[gi] <= SYNC_INIT[gi];
                    sync2_reg[gi] <= SYNC_INIT[gi];
                    sync3_reg[gi] <= SYNC_INIT[gi];
                end else begin
                    sync1_reg[gi] <= pins_raw[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                    sync3_reg[gi] <= sync2_reg[gi];
                end
            end
        end
    endgenerate

    assign srst = rst_i | ~sync2_reg[4]; // [R9]
    assign clk_rise = sync2_reg[0] & ~sync3_reg[0];
    assign mclk_rise = sync2_reg[3] & ~sync3_reg[3];
    assign fs_lvl = ctrl_reg.gci_mode ? sync2_reg[2] : sync2_reg[1];
    // Frame sync sampled on shift clock rising edges only
    assign frame_start = clk_rise & fs_lvl & ~fs_prev_reg; // [R13] [R14]
    assign half_rate = ctrl_reg.gci_mode ? fast_reg : ctrl_reg.double_clk; // [R6] [R8]
    assign bit_tick = clk_rise & (~half_rate | div_reg);
    assign advance = frame_start | (bit_tick & framed_reg);
    assign next_pos = frame_start ? 10'h000 : 10'(bit_cnt_reg + 10'h001);
    assign win = (framed_reg | frame_start) &
                 slot_window(next_pos, ctrl_reg.gci_mode, slot_reg,
                             {sync2_reg[5], sync2_reg[6]}); // [R11] [R12]
    assign load = advance & win & (next_pos[2:0] == 3'h0);

    // Clock-rate measurement, sys cycles between shift clock rising edges
    always_ff @(posedge clk_i) begin
        if (srst) begin
            per_cnt_reg <= 8'h00;
            period_reg <= 8'h00;
            fast_reg <= 1'b0;
        end else if (clk_rise) begin
            per_cnt_reg <= 8'h01;
            period_reg <= per_cnt_reg;
            // A stalled clock gives no rate reading; keep the last one
            if (ctrl_reg.gci_mode && (per_cnt_reg != 8'hFF)) begin
                fast_reg <= (per_cnt_reg <= 8'(`GCI_FAST_CYCLES)); // [R7]
            end
        end else if (per_cnt_reg != 8'hFF) begin
            per_cnt_reg <= 8'(per_cnt_reg + 8'h01);
        end
    end

    // Bit counting from frame sync
    always_ff @(posedge clk_i) begin
        if (srst) begin
            fs_prev_reg <= 1'b0;
            div_reg <= 1'b0;
            framed_reg <= 1'b0;
            bit_cnt_reg <= 10'h000;
        end else begin
            if (clk_rise) begin
                fs_prev_reg <= fs_lvl;
                div_reg <= frame_start ? 1'b0 : ~div_reg; // [R6] [R8]
            end
            if (frame_start) begin
                framed_reg <= 1'b1;
            end
            if (advance) begin
                bit_cnt_reg <= next_pos; // [R13] [R14]
            end
        end
    end

    // Serialiser; a byte is taken at its slot start, idle ones when empty
    always_ff @(posedge clk_i) begin
        if (srst) begin
            state_reg <= TX_IDLE;
            shreg_reg <= `IDLE_BYTE;
            bit_reg <= 1'b1;
        end else if (advance) begin
            if (load) begin
                state_reg <= TX_SHIFT;
                bit_reg <= fifo_out_valid ? fifo_out_data[7] : 1'b1;
                shreg_reg <= fifo_out_valid ? {fifo_out_data[6:0], 1'b1} : `IDLE_BYTE;
            end else if (win) begin
                state_reg <= TX_SHIFT;
                bit_reg <= shreg_reg[7];
                shreg_reg <= {shreg_reg[6:0], 1'b1};
            end else begin
                state_reg <= TX_IDLE;
                bit_reg <= 1'b1;
            end
        end
    end

    // Pin drivers; slot-control pins only ever pull low
    always_ff @(posedge clk_i) begin
        if (srst) begin
            port_a_reg <= '{out: 1'b1, oe: 1'b0};
            port_b_reg <= '{out: 1'b1, oe: 1'b0};
            up_reg <= '{out: 1'b1, oe: 1'b0};
            sc_a_reg <= '{out: 1'b0, oe: 1'b0}; // [R10]
            sc_b_reg <= '{out: 1'b0, oe: 1'b0}; // [R10]
        end else begin
            port_a_reg.out <= bit_reg;
            port_b_reg.out <= bit_reg;
            up_reg.out <= bit_reg;
            port_a_reg.oe <= (state_reg == TX_SHIFT) & ~ctrl_reg.gci_mode & ~ctrl_reg.port_b;
            port_b_reg.oe <= (state_reg == TX_SHIFT) & ~ctrl_reg.gci_mode & ctrl_reg.port_b;
            up_reg.oe <= (state_reg == TX_SHIFT) & ctrl_reg.gci_mode;
            sc_a_reg.oe <= (state_reg == TX_SHIFT) &
                           (ctrl_reg.gci_mode | ~ctrl_reg.port_b); // [R11] [R12]
            sc_b_reg.oe <= (state_reg == TX_SHIFT) &
                           ~ctrl_reg.gci_mode & ctrl_reg.port_b; // [R11]
        end
    end

    // Signal-processor clock tick from the chosen source, or from the shift clock in GCI mode
    always_ff @(posedge clk_i) begin
        if (srst) begin
            dsp_tick_reg <= 1'b0;
        end else begin
            dsp_tick_reg <= (ctrl_reg.dsp_from_shift | ctrl_reg.gci_mode) ?
                            clk_rise : mclk_rise; // [R5]
        end
    end

    // Wishbone decode; a data write waits while the buffer is full
    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign sel_ctrl = is_addr(wb_adr_i, `REG_CTRL_OFS);
    assign sel_slot = is_addr(wb_adr_i, `REG_SLOT_OFS);
    assign sel_txdata = is_addr(wb_adr_i, `REG_TXDATA_OFS);
    assign sel_status = is_addr(wb_adr_i, `REG_STATUS_OFS);
    assign tx_push = bus_req & wb_we_i & sel_txdata & wb_sel_i[0];
    assign ack_next = bus_req & ~(tx_push & ~fifo_in_ready);
    assign wr_en = ack_next & wb_we_i & wb_sel_i[0];
    assign status_word = {16'h0000, period_reg, 4'h0, fifo_full, fifo_empty,
                          framed_reg, fast_reg};
    assign rdata_next = sel_ctrl ? {28'h000_0000, ctrl_reg} :
                        sel_slot ? {25'h000_0000, slot_reg} :
                        sel_status ? status_word : 32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (srst) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            ctrl_reg <= `CTRL_RESET;
            slot_reg <= `SLOT_RESET;
        end else begin
            ack_reg <= ack_next;
            rdata_reg <= (ack_next & ~wb_we_i) ? rdata_next : 32'h0000_0000;
            if (wr_en & sel_ctrl) begin
                ctrl_reg <= wb_dat_i[3:0];
            end
            if (wr_en & sel_slot) begin
                slot_reg <= wb_dat_i[6:0];
            end
        end
    end

    tx_word_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(srst),
        .in_valid_i(tx_push),
        .in_ready_o(fifo_in_ready),
        .in_data_i(wb_dat_i[7:0]),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(load),
        .out_data_o(fifo_out_data),
        .full_o(fifo_full),
        .empty_o(fifo_empty)
    );

    assign wb_dat_o = rdata_reg;
    assign wb_ack_o = ack_reg;
    assign tx_highway_port_a_o = port_a_reg.out;
    assign tx_highway_port_a_oe_o = port_a_reg.oe;
    assign tx_highway_port_b_o = port_b_reg.out;
    assign tx_highway_port_b_oe_o = port_b_reg.oe;
    assign gci_upstream_line_o = up_reg.out;
    assign gci_upstream_line_oe_o = up_reg.oe;
    assign slot_ctrl_out_a_o = sc_a_reg.out;
    assign slot_ctrl_out_a_oe_o = sc_a_reg.oe;
    assign slot_ctrl_out_b_o = sc_b_reg.out;
    assign slot_ctrl_out_b_oe_o = sc_b_reg.oe;
    assign dsp_clk_tick_o = dsp_tick_reg;
    assign gci_fast_clk_o = fast_reg; // [R7]

endmodule

`default_nettype wire

// file: verilog/tx_word_fifo.sv
/*
 * Flip-flop FIFO with valid/ready on both sides, width and depth as
 * parameters.
 * Assumes one clock and a synchronous active-high reset; depth a power of two.
 */
`default_nettype none

module tx_word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    // Level flags
    output logic full_o,
    output logic empty_o
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    wire logic push;
    wire logic pop;

    assign full_o = (count_reg == (AW+1)'(DEPTH));
    assign empty_o = (count_reg == '0);
    assign in_ready_o = ~full_o;
    assign out_valid_o = ~empty_o;
    assign out_data_o = mem_reg[rd_ptr_reg];
    assign push = in_valid_i & ~full_o;
    assign pop = out_ready_i & ~empty_o;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            wr_ptr_reg <= push ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
            rd_ptr_reg <= pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
            count_reg <= (AW+1)'(count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
        end
    end

endmodule

`default_nettype wire
